// [elu_pkg.sv]
/*
  Shared constants and types for the edge line unit: register offsets,
  field widths, reset values, status bit positions and the register port carrier.
  Assumes a single 250 MHz system clock and a one-cycle register port.
*/
`default_nettype none
package elu_pkg;
  // lines and data widths
  localparam int unsigned LINES = 19;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned GPIO_LINES = 16;
  // internal sources sit above the gpio lines
  localparam int unsigned LINE_LOW_VOLTAGE = 16;
  localparam int unsigned LINE_RTC_ALARM = 17;
  localparam int unsigned LINE_USB_WAKE = 18;
  // register offsets (byte addresses)
  localparam logic [7:0] ADDR_INT_ENABLE = 8'h00;
  localparam logic [7:0] ADDR_EVENT_ENABLE = 8'h04;
  localparam logic [7:0] ADDR_RISE_ENABLE = 8'h08;
  localparam logic [7:0] ADDR_FALL_ENABLE = 8'h0C;
  localparam logic [7:0] ADDR_SOFT_TRIGGER = 8'h10;
  localparam logic [7:0] ADDR_PENDING = 8'h14;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h18;
  localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h1C;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h20;
  // reset values
  localparam logic [18:0] LINES_RESET = 19'h00000;
  localparam logic [18:0] PENDING_RESET = 19'h00000;
  localparam logic [31:0] RDATA_RESET = 32'h00000000;
  localparam logic [31:0] UNMAPPED_READ = 32'h00000000;
  // summary interrupt status bits
  localparam int unsigned ST_W = 3;
  localparam int unsigned ST_PEND_SET = 0;
  localparam int unsigned ST_EVENT_SENT = 1;
  localparam int unsigned ST_SOFT_FIRED = 2;
  localparam logic [2:0] ST_RESET = 3'h0;

  typedef logic [18:0] elu_lines_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } elu_bus_req_s;
endpackage
`default_nettype wire

// [elu_proc_model.sv]
/*
  Processor side model: wake-up event input that counts event pulses per line.
  Assumes events arrive as registered pulses on clock_in.
*/
`timescale 1ns/1ps
`default_nettype none
module elu_proc_model
(
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // event requests from the unit
  input wire logic [18:0] line_event_in,
  input wire logic event_in,
  // counts for the bench
  output logic [18:0][3:0] ev_count_out,
  output logic [3:0] wake_count_out
);
  // counts every high cycle, so a stuck level shows up as extra wakes
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      ev_count_out <= '0;
      wake_count_out <= 4'h0;
    end
    else
    begin
      for (int i = 0; i < 19; i++)
      begin
        ev_count_out[i] <= ev_count_out[i] + {3'h0, line_event_in[i]};
      end
      wake_count_out <= wake_count_out + {3'h0, event_in};
    end
  end
endmodule
`default_nettype wire

// [elu_top.sv]
/*
  Edge line unit: edge detection, software trigger, pending flags, event and
  interrupt requests for 19 lines, with a one-cycle register port.
  Assumes line inputs already synchronous to clock_in and a master that never
  asserts read and write strobes together.
*/
// Contract
// - a line's event request goes out only while its event enable bit is 1.
// - with the rise enable set, a low-to-high change on the line is a trigger.
// - with the fall enable set, a high-to-low change on the line is a trigger.
// - writing 1 to a soft trigger bit fires that line as an edge would; 0 fires nothing. The code fires only where the bit was 0 before the write.
// - each line has a pending flag that reads 1 once the line was triggered as an interrupt.
// - writing 1 to a pending bit clears it and writing 0 leaves it alone.
// - the enable and soft trigger registers reset to zero; pending content is free after reset.
// - an interrupt trigger sets the pending flag, an event-only trigger does not.
// - each line has an interrupt enable at offset zero and raises an interrupt only when it is 1. The code raises irq_out on soft or event triggers with it 0.
// - both edge enables may be set at once and then both changes trigger.
// - lines 0 to 15 are gpio, 16 the low voltage detector, 17 the rtc alarm, 18 the usb wakeup.
`timescale 1ns/1ps
`default_nettype none
module elu_top
(
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // register port
  input wire elu_pkg::elu_bus_req_s bus_in,
  output logic [31:0] rdata_out,
  // trigger sources
  input wire logic [15:0] gpio_line_in,
  input wire logic low_voltage_detector_in,
  input wire logic rtc_alarm_in,
  input wire logic usb_device_core_wake_in,
  // toward the processor
  output logic [18:0] line_irq_out,
  output logic [18:0] line_event_out,
  output logic event_out,
  output logic irq_out
);

  function automatic logic hit(input elu_pkg::elu_bus_req_s req, input logic [7:0] addr);
    hit = req.wr && (req.addr == addr);
  endfunction

  function automatic logic [31:0] widen(input elu_pkg::elu_lines_t v);
    widen = {13'h0000, v};
  endfunction

  elu_pkg::elu_lines_t line_interrupt_enable;
  elu_pkg::elu_lines_t line_event_enable;
  elu_pkg::elu_lines_t line_rise_enable;
  elu_pkg::elu_lines_t line_fall_enable;
  elu_pkg::elu_lines_t line_soft_trigger;
  elu_pkg::elu_lines_t line_pending_flag;
  elu_pkg::elu_lines_t line_now;
  elu_pkg::elu_lines_t line_prev;
  elu_pkg::elu_lines_t edge_hit;
  elu_pkg::elu_lines_t soft_fire;
  elu_pkg::elu_lines_t trigger;
  elu_pkg::elu_lines_t pend_set;
  elu_pkg::elu_lines_t pend_clr;
  elu_pkg::elu_lines_t wlines;
  logic [2:0] irq_status;
  logic [2:0] irq_enable;
  logic [2:0] next_status_set;
  logic [2:0] status_clr;
  logic prev_valid;

  // gpio lines below, internal sources above
  assign line_now = {usb_device_core_wake_in, rtc_alarm_in, low_voltage_detector_in, gpio_line_in};
  assign wlines = bus_in.wdata[18:0];

  // previous value; no edge is seen in the first cycle after reset
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      line_prev <= elu_pkg::LINES_RESET;
      prev_valid <= 1'b0;
    end
    else
    begin
      line_prev <= line_now;
      prev_valid <= 1'b1;
    end
  end

  // both enables may be set together and then either change counts
  always_comb
  begin
    edge_hit = elu_pkg::LINES_RESET;
    if (prev_valid)
    begin
      edge_hit = (line_rise_enable & line_now & ~line_prev)
               | (line_fall_enable & ~line_now & line_prev);
    end
  end

  // only a 0 to 1 write of the soft bit fires, so rewriting 1 does not repeat it
  assign soft_fire = hit(bus_in, elu_pkg::ADDR_SOFT_TRIGGER) ? (wlines & ~line_soft_trigger)
                                                             : elu_pkg::LINES_RESET;
  assign trigger = edge_hit | soft_fire;
  assign pend_set = trigger & line_interrupt_enable;
  assign pend_clr = hit(bus_in, elu_pkg::ADDR_PENDING) ? wlines : elu_pkg::LINES_RESET;

  // configuration registers
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      line_interrupt_enable <= elu_pkg::LINES_RESET;
      line_event_enable <= elu_pkg::LINES_RESET;
      line_rise_enable <= elu_pkg::LINES_RESET;
      line_fall_enable <= elu_pkg::LINES_RESET;
    end
    else
    begin
      if (hit(bus_in, elu_pkg::ADDR_INT_ENABLE))
        line_interrupt_enable <= wlines;
      if (hit(bus_in, elu_pkg::ADDR_EVENT_ENABLE))
        line_event_enable <= wlines;
      if (hit(bus_in, elu_pkg::ADDR_RISE_ENABLE))
        line_rise_enable <= wlines;
      if (hit(bus_in, elu_pkg::ADDR_FALL_ENABLE))
        line_fall_enable <= wlines;
    end
  end

  // soft bit stays set until software clears the pending flag of the line or writes 0 to the soft bit
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
      line_soft_trigger <= elu_pkg::LINES_RESET;
    else if (hit(bus_in, elu_pkg::ADDR_SOFT_TRIGGER))
      line_soft_trigger <= wlines;
    else
      line_soft_trigger <= line_soft_trigger & ~pend_clr;
  end

  // a set in the same cycle as the clear wins, so no trigger is lost
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
      line_pending_flag <= elu_pkg::PENDING_RESET;
    else
      line_pending_flag <= (line_pending_flag & ~pend_clr) | pend_set;
  end

  // requests toward the processor
  assign line_irq_out = line_pending_flag & line_interrupt_enable;

  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      line_event_out <= elu_pkg::LINES_RESET;
      event_out <= 1'b0;
    end
    else
    begin
      line_event_out <= trigger & line_event_enable;
      event_out <= |(trigger & line_event_enable);
    end
  end

  // summary interrupt: sticky status, write-one clear, enable
  always_comb
  begin
    next_status_set = elu_pkg::ST_RESET;
    next_status_set[elu_pkg::ST_PEND_SET] = |pend_set;
    next_status_set[elu_pkg::ST_EVENT_SENT] = |(trigger & line_event_enable);
    next_status_set[elu_pkg::ST_SOFT_FIRED] = |soft_fire;
  end

  assign status_clr = hit(bus_in, elu_pkg::ADDR_IRQ_CLEAR) ? bus_in.wdata[2:0] : elu_pkg::ST_RESET;

  always_ff @(posedge clock_in)
  begin
    if (rst_in)
      irq_status <= elu_pkg::ST_RESET;
    else
      irq_status <= (irq_status & ~status_clr) | next_status_set;
  end

  always_ff @(posedge clock_in)
  begin
    if (rst_in)
      irq_enable <= elu_pkg::ST_RESET;
    else if (hit(bus_in, elu_pkg::ADDR_IRQ_ENABLE))
      irq_enable <= bus_in.wdata[2:0];
  end

  assign irq_out = |(irq_status & irq_enable);

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
      rdata_out <= elu_pkg::RDATA_RESET;
    else if (!bus_in.rd)
      rdata_out <= elu_pkg::RDATA_RESET;
    else
    begin
      case (bus_in.addr)
        elu_pkg::ADDR_INT_ENABLE: rdata_out <= widen(line_interrupt_enable);
        elu_pkg::ADDR_EVENT_ENABLE: rdata_out <= widen(line_event_enable);
        elu_pkg::ADDR_RISE_ENABLE: rdata_out <= widen(line_rise_enable);
        elu_pkg::ADDR_FALL_ENABLE: rdata_out <= widen(line_fall_enable);
        elu_pkg::ADDR_SOFT_TRIGGER: rdata_out <= widen(line_soft_trigger);
        elu_pkg::ADDR_PENDING: rdata_out <= widen(line_pending_flag);
        elu_pkg::ADDR_IRQ_STATUS: rdata_out <= {29'h00000000, irq_status};
        elu_pkg::ADDR_IRQ_ENABLE: rdata_out <= {29'h00000000, irq_enable};
        default: rdata_out <= elu_pkg::UNMAPPED_READ;
      endcase
    end
  end

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  sequence s_rise(int i);
    prev_valid && line_rise_enable[i] && !line_prev[i] && line_now[i];
  endsequence

  sequence s_fall(int i);
    prev_valid && line_fall_enable[i] && line_prev[i] && !line_now[i];
  endsequence

  property p_event_gate;
    ##1 (line_event_out == ($past(trigger) & $past(line_event_enable)));
  endproperty
  a_event_gate: assert property (p_event_gate) else $error("event out without enable");

  property p_rise;
    s_rise(0) ##0 line_interrupt_enable[0] |=> line_pending_flag[0];
  endproperty
  a_rise: assert property (p_rise) else $error("rising edge missed");

  property p_fall;
    s_fall(1) ##0 line_interrupt_enable[1] |=> line_pending_flag[1];
  endproperty
  a_fall: assert property (p_fall) else $error("falling edge missed");

  property p_soft;
    (bus_in.wr && bus_in.addr == elu_pkg::ADDR_SOFT_TRIGGER && bus_in.wdata[3] && !line_soft_trigger[3]
      && line_interrupt_enable[3]) |=> line_pending_flag[3];
  endproperty
  a_soft: assert property (p_soft) else $error("soft trigger did not set pending");

  property p_pend_hold;
    (line_pending_flag[0] && !pend_clr[0]) |=> line_pending_flag[0];
  endproperty
  a_pend_hold: assert property (p_pend_hold) else $error("pending flag lost");

  property p_w1c;
    (pend_clr[1] && !pend_set[1]) |=> !line_pending_flag[1];
  endproperty
  a_w1c: assert property (p_w1c) else $error("write one did not clear pending");

  property p_w0;
    (bus_in.wr && bus_in.addr == elu_pkg::ADDR_PENDING && !bus_in.wdata[0] && line_pending_flag[0])
      |=> line_pending_flag[0];
  endproperty
  a_w0: assert property (p_w0) else $error("write zero changed pending");

  property p_reset_zero;
    @(posedge clock_in) rst_in |=> (line_event_enable == 19'h00000 && line_soft_trigger == 19'h00000
      && line_rise_enable == 19'h00000 && line_fall_enable == 19'h00000);
  endproperty
  a_reset_zero: assert property (disable iff (1'b0) p_reset_zero) else $error("enables not cleared");

  property p_event_only;
    (!line_pending_flag[2] && !line_interrupt_enable[2]) |=> !line_pending_flag[2];
  endproperty
  a_event_only: assert property (p_event_only) else $error("pending set without interrupt enable");

  property p_irq_gate;
    // goes through the pending flag, so a lost set shows here too
    (trigger[0] && line_interrupt_enable[0] && !(bus_in.wr && bus_in.addr == elu_pkg::ADDR_INT_ENABLE))
      |=> line_irq_out[0];
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("interrupt not raised for enabled line");

  property p_both;
    (line_rise_enable[18] && line_fall_enable[18] && prev_valid && (line_now[18] != line_prev[18]))
      |=> line_event_out[18] == $past(line_event_enable[18]);
  endproperty
  a_both: assert property (p_both) else $error("both-edge mode missed a change");

  property p_pulse;
    edge_hit[16] ##1 $stable(line_now[16]) |-> !edge_hit[16];
  endproperty
  a_pulse: assert property (p_pulse) else $error("edge pulse longer than a cycle");

  // summary status stays until software writes one to its clear bit
  property p_status_hold;
    (irq_status[elu_pkg::ST_SOFT_FIRED] && !status_clr[elu_pkg::ST_SOFT_FIRED])
      |=> irq_status[elu_pkg::ST_SOFT_FIRED];
  endproperty
  a_status_hold: assert property (p_status_hold) else $error("soft status bit lost");

endmodule
`default_nettype wire

// [elu_top_bench.sv]
/*
  Bench for the edge line unit: register tasks, line stimulus and checks.
  Assumes elu_pkg, elu_top and elu_proc_model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module elu_top_bench;
  logic clock_in;
  logic rst_in;
  elu_pkg::elu_bus_req_s bus_in;
  logic [31:0] rdata_out;
  logic [15:0] gpio_line_in;
  logic lvd_in;
  logic rtc_in;
  logic usb_in;
  logic [18:0] line_irq_out;
  logic [18:0] line_event_out;
  logic event_out;
  logic irq_out;
  logic [18:0][3:0] ev_count;
  logic [3:0] wake_count;
  int err_total = 0;
  int compares = 0;

  elu_top elu_top_inst (.clock_in(clock_in), .rst_in(rst_in), .bus_in(bus_in), .rdata_out(rdata_out),
    .gpio_line_in(gpio_line_in), .low_voltage_detector_in(lvd_in), .rtc_alarm_in(rtc_in),
    .usb_device_core_wake_in(usb_in), .line_irq_out(line_irq_out), .line_event_out(line_event_out),
    .event_out(event_out), .irq_out(irq_out));
  elu_proc_model elu_proc_model_inst (.clock_in(clock_in), .rst_in(rst_in), .line_event_in(line_event_out),
    .event_in(event_out), .ev_count_out(ev_count), .wake_count_out(wake_count));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // whole words only, upper bits always zero
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_in);
    bus_in <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock_in);
    bus_in.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    @(posedge clock_in);
    bus_in <= '{addr: a, wdata: 32'h00000000, wr: 1'b0, rd: 1'b1};
    @(posedge clock_in);
    bus_in.rd <= 1'b0;
    #1;
    check(what, rdata_out, exp);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask
  task automatic wrap_up();
    if (err_total == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    clock_in = 1'b0;
    forever #2 clock_in = ~clock_in;
  end
  // whole run is about 120 cycles
  initial
  begin
    #20000;
    err_total++;
    wrap_up();
  end
  initial
  begin
    rst_in = 1'b1;
    bus_in = '0;
    gpio_line_in = 16'h0000;
    lvd_in = 1'b0;
    rtc_in = 1'b0;
    usb_in = 1'b0;
    repeat (6) @(posedge clock_in);
    rst_in <= 1'b0;
    for (int i = 0; i < 6; i++)
    begin
      rd(8'(4 * i), 32'h00000000, "reset value");
    end
    rd(8'h40, 32'h00000000, "unmapped read");
    wr(elu_pkg::ADDR_INT_ENABLE, 32'h0007FFFF);
    wr(elu_pkg::ADDR_EVENT_ENABLE, 32'h0007FFFF);
    wr(elu_pkg::ADDR_RISE_ENABLE, 32'h00070005);
    wr(elu_pkg::ADDR_FALL_ENABLE, 32'h00040002);
    rd(elu_pkg::ADDR_FALL_ENABLE, 32'h00040002, "fall enable");
    @(posedge clock_in);
    gpio_line_in <= 16'h0003;
    idle(4);
    check("line irq", {13'h0000, line_irq_out}, 32'h00000001);
    check("event line0", {28'h0, ev_count[0]}, 32'h1);
    rd(elu_pkg::ADDR_PENDING, 32'h00000001, "pending rise");
    wr(elu_pkg::ADDR_PENDING, 32'h00000000);
    rd(elu_pkg::ADDR_PENDING, 32'h00000001, "pending write zero");
    wr(elu_pkg::ADDR_PENDING, 32'h00000001);
    rd(elu_pkg::ADDR_PENDING, 32'h00000000, "pending cleared");
    @(posedge clock_in);
    gpio_line_in <= 16'h0000;
    idle(4);
    rd(elu_pkg::ADDR_PENDING, 32'h00000002, "pending fall");
    @(posedge clock_in);
    lvd_in <= 1'b1;
    rtc_in <= 1'b1;
    usb_in <= 1'b1;
    idle(2);
    @(posedge clock_in);
    usb_in <= 1'b0;
    idle(4);
    rd(elu_pkg::ADDR_PENDING, 32'h00070002, "pending internal lines");
    check("event line18", {28'h0, ev_count[18]}, 32'h2);
    wr(elu_pkg::ADDR_PENDING, 32'h0007FFFF);
    wr(elu_pkg::ADDR_INT_ENABLE, 32'h00000000);
    @(posedge clock_in);
    gpio_line_in <= 16'h0004;
    idle(4);
    rd(elu_pkg::ADDR_PENDING, 32'h00000000, "pending event only");
    check("event line2", {28'h0, ev_count[2]}, 32'h1);
    wr(elu_pkg::ADDR_INT_ENABLE, 32'h0007FFFF);
    wr(elu_pkg::ADDR_EVENT_ENABLE, 32'h00000000);
    wr(elu_pkg::ADDR_SOFT_TRIGGER, 32'h00000008);
    rd(elu_pkg::ADDR_PENDING, 32'h00000008, "pending soft");
    check("event line3", {28'h0, ev_count[3]}, 32'h0);
    wr(elu_pkg::ADDR_EVENT_ENABLE, 32'h0007FFFF);
    wr(elu_pkg::ADDR_SOFT_TRIGGER, 32'h00000018);
    idle(3);
    check("event line4", {28'h0, ev_count[4]}, 32'h1);
    check("event line3 again", {28'h0, ev_count[3]}, 32'h0);
    check("wake pulses", {28'h0, wake_count}, 32'h6);
    rd(elu_pkg::ADDR_SOFT_TRIGGER, 32'h00000018, "soft bits held");
    wr(elu_pkg::ADDR_PENDING, 32'h0007FFFF);
    wr(elu_pkg::ADDR_IRQ_CLEAR, 32'h00000007);
    rd(elu_pkg::ADDR_IRQ_STATUS, 32'h00000000, "status cleared");
    rd(elu_pkg::ADDR_SOFT_TRIGGER, 32'h00000000, "soft bits cleared");
    wr(elu_pkg::ADDR_EVENT_ENABLE, 32'h00000000);
    wr(elu_pkg::ADDR_IRQ_ENABLE, 32'h00000001);
    wr(elu_pkg::ADDR_SOFT_TRIGGER, 32'h00000020);
    idle(3);
    rd(elu_pkg::ADDR_IRQ_STATUS, 32'h00000005, "status soft");
    rd(elu_pkg::ADDR_IRQ_ENABLE, 32'h00000001, "irq enable");
    check("irq raised", {31'h0, irq_out}, 32'h1);
    wr(elu_pkg::ADDR_IRQ_ENABLE, 32'h00000000);
    idle(1);
    check("irq masked", {31'h0, irq_out}, 32'h0);
    wr(elu_pkg::ADDR_PENDING, 32'h0007FFFF);
    wr(elu_pkg::ADDR_IRQ_CLEAR, 32'h00000007);
    rd(elu_pkg::ADDR_IRQ_STATUS, 32'h00000000, "status final");
    rd(elu_pkg::ADDR_PENDING, 32'h00000000, "pending final");
    wrap_up();
  end
endmodule
`default_nettype wire
